// *** hdl/dbc_core.sv ***
// doorbell completion reporting and interrupt registers
`default_nettype none
`include "dbc_map.svh"
// Functional notes
// [RULE1] error-report bit high queues error or timed-out doorbells; low drops them
// [RULE2] success-report bit high queues successful responses; low discards them
// [RULE3] enable register: bit2 overflow, bit1 completion, bit0 reception; reset zero
// [RULE4] overflow status sets on fifo overflow, holds until one entry is read
// [RULE5] software clears overflow by writing one after reading an entry
// [RULE6] completion status sets on new completion; write one clears, zero keeps
// [RULE7] reception status sets on inbound doorbell; write one clears, zero keeps
// [RULE8] completion fifo holds sixteen entries; any further entry is overflow
// [RULE9] result of last read entry: 00 done, 01 error, 10 time-out
// [RULE10] interrupt output high while any status bit and its enable are set
module dbc_core
  import dbc_pkg::*;
#(
  parameter int CPL_DEPTH = `DBC_CPL_DEPTH
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire dbc_pkg::dbc_bus_s busReq,
  output logic [31:0]            busRdata,
  input  wire logic              txDoneValid,
  input  wire dbc_pkg::dbc_cpl_s txDoneData,
  input  wire logic              rxDoorbellPulse,
  output logic                   doorbellIrq
);
  import dbc_pkg::*;

  logic [1:0]  reportCtrl_reg;
  logic [2:0]  irqEnable_reg;
  dbc_result_t lastResult_reg;
  logic        ovfHold_reg;
  logic [31:0] rdata_reg;
  logic        pushValid;
  logic        popReq;
  logic        popDone;
  logic        overflowPulse;
  logic [7:0]  cplLevel;
  dbc_cpl_s    headData;
  logic [2:0]  status;
  logic [2:0]  setEvt;
  logic [2:0]  clrMask;
  logic [2:0]  clrAllow;
  logic        wrHit;

  // true for a write strobe aimed at the given offset
  function automatic logic wrAt(input dbc_bus_s b, input logic [7:0] off);
    return b.wr && (b.addr == off);
  endfunction : wrAt

  // filter finished doorbells by result class
  always_comb begin
    pushValid = 1'b0;
    if (txDoneValid) begin
      if (txDoneData.result == `DBC_RES_DONE) begin
        pushValid = reportCtrl_reg[`DBC_BIT_REPORT_OK]; // see [RULE2]
      end else begin
        pushValid = reportCtrl_reg[`DBC_BIT_REPORT_ERR]; // see [RULE1]
      end
    end
  end

  // reading the entry register pops the fifo head
  assign popReq = busReq.rd && (busReq.addr == `DBC_OFF_CPL_ENTRY);

  dbc_cpl_fifo #(
    .DEPTH (CPL_DEPTH)
  ) u_fifo (
    .core_clk      (core_clk),
    .rst           (rst),
    .pushValid     (pushValid),
    .pushData      (txDoneData),
    .popReq        (popReq),
    .headData      (headData),
    .popDone       (popDone),
    .overflowPulse (overflowPulse),
    .level         (cplLevel)
  );

  // control registers written by software
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reportCtrl_reg <= `DBC_CTRL_RESET;
      irqEnable_reg  <= `DBC_IRQ_RESET; // see [RULE3]
    end else begin
      if (wrAt(busReq, `DBC_OFF_REPORT_CTRL)) begin
        reportCtrl_reg <= busReq.wdata[1:0];
      end
      if (wrAt(busReq, `DBC_OFF_IRQ_ENABLE)) begin
        irqEnable_reg <= busReq.wdata[2:0]; // see [RULE3]
      end
    end
  end

  // result of the entry most recently popped; captured on the read itself
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastResult_reg <= `DBC_RES_DONE;
    end else if (popReq && (cplLevel != 8'h00)) begin
      lastResult_reg <= headData.result; // see [RULE9]
    end
  end

  // overflow may only be cleared once an entry has been read since it was raised
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovfHold_reg <= 1'b0;
    end else if (overflowPulse) begin
      ovfHold_reg <= 1'b1; // see [RULE4]
    end else if (popDone) begin
      ovfHold_reg <= 1'b0;
    end
  end

  // status events and write-one-to-clear
  assign wrHit = wrAt(busReq, `DBC_OFF_IRQ_STATUS);
  always_comb begin
    setEvt = '0;
    setEvt[`DBC_BIT_OVF] = overflowPulse; // see [RULE4]
    // same room test as the fifo, so the bit rises exactly when an entry lands
    setEvt[`DBC_BIT_CPL] = pushValid && (cplLevel < 8'(CPL_DEPTH)); // see [RULE6]
    setEvt[`DBC_BIT_RX]  = rxDoorbellPulse; // see [RULE7]
    clrMask  = wrHit ? busReq.wdata[2:0] : 3'h0;
    clrAllow = 3'h7;
    clrAllow[`DBC_BIT_OVF] = !ovfHold_reg; // see [RULE5]
  end

  dbc_irq_status #(
    .N (3)
  ) u_irq (
    .core_clk (core_clk),
    .rst      (rst),
    .setEvt   (setEvt),
    .clrMask  (clrMask),
    .clrAllow (clrAllow),
    .enable   (irqEnable_reg),
    .status   (status),
    .irq      (doorbellIrq)
  );

  // read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rdata_reg <= 32'h0;
    end else if (busReq.rd) begin
      case (busReq.addr)
        `DBC_OFF_CPL_ENTRY: begin
          rdata_reg <= (cplLevel != 8'h00) ?
            {headData.largeDestId, headData.destId, headData.info} : 32'h0;
        end
        `DBC_OFF_CPL_RESULT:  rdata_reg <= {30'h0, lastResult_reg};
        `DBC_OFF_REPORT_CTRL: rdata_reg <= {30'h0, reportCtrl_reg};
        `DBC_OFF_IRQ_ENABLE:  rdata_reg <= {29'h0, irqEnable_reg};
        `DBC_OFF_IRQ_STATUS:  rdata_reg <= {29'h0, status};
        `DBC_OFF_CPL_LEVEL:   rdata_reg <= {24'h0, cplLevel};
        default:              rdata_reg <= 32'h0;
      endcase
    end else begin
      rdata_reg <= 32'h0;
    end
  end
  assign busRdata = rdata_reg;
endmodule : dbc_core
`default_nettype wire

// *** hdl/dbc_map.svh ***
// register offsets, field positions, reset values and sizes of the doorbell completion block
`ifndef DBC_MAP_SVH
`define DBC_MAP_SVH
`define DBC_OFF_CPL_ENTRY    8'h14
`define DBC_OFF_CPL_RESULT   8'h18
`define DBC_OFF_REPORT_CTRL  8'h1C
`define DBC_OFF_IRQ_ENABLE   8'h20
`define DBC_OFF_IRQ_STATUS   8'h24
`define DBC_OFF_CPL_LEVEL    8'h28
`define DBC_BIT_REPORT_OK    0
`define DBC_BIT_REPORT_ERR   1
`define DBC_BIT_RX           0
`define DBC_BIT_CPL          1
`define DBC_BIT_OVF          2
`define DBC_CTRL_RESET       2'h0
`define DBC_IRQ_RESET        3'h0
`define DBC_RES_DONE         2'h0
`define DBC_RES_ERROR        2'h1
`define DBC_RES_TIMEOUT      2'h2
`define DBC_CPL_DEPTH        16
`endif

// *** hdl/dbc_pkg.sv ***
// types shared by the doorbell completion block
`default_nettype none
package dbc_pkg;
  typedef logic [1:0] dbc_result_t;
  // one finished outbound doorbell: target ids, info field and result
  typedef struct packed {
    logic [7:0]  largeDestId;
    logic [7:0]  destId;
    logic [15:0] info;
    dbc_result_t result;
  } dbc_cpl_s;
  // register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dbc_bus_s;
  localparam int DBC_CPL_W = $bits(dbc_cpl_s);
endpackage : dbc_pkg
`default_nettype wire

// *** hdl/dbc_cpl_fifo.sv ***
// completion fifo of finished outbound doorbells with overflow pulse
`default_nettype none
`include "dbc_map.svh"
module dbc_cpl_fifo
  import dbc_pkg::*;
#(
  parameter int DEPTH = `DBC_CPL_DEPTH
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             pushValid,
  input  wire dbc_pkg::dbc_cpl_s pushData,
  input  wire logic             popReq,
  output dbc_pkg::dbc_cpl_s     headData,
  output logic                  popDone,
  output logic                  overflowPulse,
  output logic [7:0]            level
);
  localparam int AW = $clog2(DEPTH);
  dbc_cpl_s             mem [DEPTH];
  logic [AW-1:0]        wrPtr_reg;
  logic [AW-1:0]        rdPtr_reg;
  logic [AW:0]          count_reg;
  logic                 doPush;
  logic                 doPop;

  // a push into a full fifo is dropped and flagged; a same-cycle pop frees no room first
  assign doPop = popReq && (count_reg != '0);
  assign doPush = pushValid && (count_reg != (AW+1)'(DEPTH));
  assign headData = mem[rdPtr_reg];
  assign level = 8'(count_reg);

  // storage, written only when room exists
  always_ff @(posedge core_clk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= pushData;
    end
  end

  // pointers and occupancy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (doPop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(doPush) - (AW+1)'(doPop);
    end
  end

  // one-cycle event outputs
  always_ff @(posedge core_clk) begin
    if (rst) begin
      popDone       <= 1'b0;
      overflowPulse <= 1'b0;
    end else begin
      popDone       <= doPop;
      overflowPulse <= pushValid && !doPush; // see [RULE8]
    end
  end
endmodule : dbc_cpl_fifo
`default_nettype wire

// *** hdl/dbc_irq_status.sv ***
// sticky write-one-to-clear status bits with mask and level interrupt
`default_nettype none
module dbc_irq_status #(
  parameter int N = 3
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [N-1:0] setEvt,
  input  wire logic [N-1:0] clrMask,
  input  wire logic [N-1:0] clrAllow,
  input  wire logic [N-1:0] enable,
  output logic [N-1:0]      status,
  output logic              irq
);
  // set wins over a clear in the same cycle; clrAllow holds off clears that are not yet legal
  always_ff @(posedge core_clk) begin
    if (rst) begin
      status <= '0;
    end else begin
      status <= setEvt | (status & ~(clrMask & clrAllow)); // see [RULE6] see [RULE7]
    end
  end

  // level interrupt, high while any enabled bit is set
  assign irq = |(status & enable); // see [RULE10]
endmodule : dbc_irq_status
`default_nettype wire

// *** tb/dbc_core_properties.sv ***
// port assertions for the doorbell completion core
`default_nettype none
module dbc_core_properties #(parameter int CPL_DEPTH = 16) (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire dbc_pkg::dbc_bus_s busReq,
  input wire logic [31:0]       busRdata,
  input wire logic              txDoneValid,
  input wire dbc_pkg::dbc_cpl_s txDoneData,
  input wire logic              rxDoorbellPulse,
  input wire logic              doorbellIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbc_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [1:0] ctl;
  logic [2:0] en;
  int         cnt;
  wire logic  wEn = busReq.wr && busReq.addr == 8'h20;
  wire logic  pop = busReq.rd && busReq.addr == 8'h14 && cnt > 0;
  wire logic  q = txDoneValid && cnt < CPL_DEPTH
                  && (txDoneData.result == 2'h0 ? ctl[0] : ctl[1]);
  sequence rdS(logic [7:0] a);
    busReq.rd && busReq.addr == a;
  endsequence
  // exact occupancy model; a push into a full fifo is lost even beside a pop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctl <= 2'h0;
      en <= 3'h0;
      cnt <= 0;
    end else begin
      if (busReq.wr && busReq.addr == 8'h1C) ctl <= busReq.wdata[1:0];
      if (wEn) en <= busReq.wdata[2:0];
      cnt <= cnt + int'(q) - int'(pop);
    end
  end
  a_ctrl_back: assert property (rdS(8'h1C) |=> busRdata == {30'h0, ctl})
    else $error("control readback wrong");
  a_en_back: assert property (rdS(8'h20) |=> busRdata == {29'h0, en})
    else $error("enable readback wrong");
  a_rx_irq: assert property (rxDoorbellPulse && en[0] && !wEn |=> doorbellIrq)
    else $error("reception left irq low");
  a_cpl_irq: assert property (q && en[1] && !wEn |=> doorbellIrq)
    else $error("completion left irq low");
  a_irq_quiet: assert property (en == 3'h0 |-> !doorbellIrq)
    else $error("irq high with all enables off");
  a_rx_stat: assert property (rxDoorbellPulse ##1 rdS(8'h24) |=> busRdata[0])
    else $error("reception status not set");
  a_cpl_stat: assert property (q ##1 rdS(8'h24) |=> busRdata[1])
    else $error("completion status not set");
  a_w1c_rx: assert property (busReq.wr && busReq.addr == 8'h24 && busReq.wdata[0]
    && !rxDoorbellPulse ##1 rdS(8'h24) |=> !busRdata[0]) else $error("reception not cleared");
  a_level_back: assert property (rdS(8'h28) |=> busRdata == $past(cnt))
    else $error("fifo level readback wrong");
  c_rx: cover property (rxDoorbellPulse && en[0]);
  c_queue: cover property (q);
  c_clear: cover property (busReq.wr && busReq.addr == 8'h24);
endmodule : dbc_core_properties
bind dbc_core dbc_core_properties #(.CPL_DEPTH(CPL_DEPTH)) u_props (.core_clk(core_clk),
  .rst(rst), .busReq(busReq), .busRdata(busRdata), .txDoneValid(txDoneValid),
  .txDoneData(txDoneData), .rxDoorbellPulse(rxDoorbellPulse), .doorbellIrq(doorbellIrq));
`default_nettype wire

// *** tb/dbc_core_test.sv ***
// self-checking bench for the doorbell completion core
`default_nettype none
module dbc_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dbc_pkg::*;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  dbc_bus_s    busReq = '0;
  logic [31:0] busRdata;
  logic        txDoneValid = 1'b0;
  dbc_cpl_s    txDoneData = '0;
  logic        rxDoorbellPulse = 1'b0;
  logic        doorbellIrq;
  logic [31:0] v;
  logic [1:0]  lastRes = 2'h0;
  int          fails = 0;
  int          checks_done = 0;
  int          cyc = 0;
  // rows: report control, result, queued
  logic [4:0]  rows [8] = '{5'h09, 5'h10, 5'h13, 5'h0A, 5'h15, 5'h0C, 5'h1D, 5'h00};
  logic [7:0]  regs [4] = '{8'h1C, 8'h20, 8'h24, 8'h28};
  dbc_core #(.CPL_DEPTH(16)) DUT (.core_clk(core_clk), .rst(rst), .busReq(busReq),
    .busRdata(busRdata), .txDoneValid(txDoneValid), .txDoneData(txDoneData),
    .rxDoorbellPulse(rxDoorbellPulse), .doorbellIrq(doorbellIrq));
  always #5 core_clk = ~core_clk;
  // a hang counts as a mismatch
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    busReq <= '{a, d, 1'b1, 1'b0};
    @(posedge core_clk);
    busReq.wr <= 1'b0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    busReq <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    busReq.rd <= 1'b0;
    #1 v = busRdata;
  endtask : rd
  task automatic push(input logic [1:0] r);
    @(posedge core_clk);
    txDoneValid <= 1'b1;
    txDoneData <= '{8'hA5, 8'h3C, 16'h1234 + r, r};
    @(posedge core_clk);
    txDoneValid <= 1'b0;
  endtask : push
  task automatic final_report();
    if (fails == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      wr(8'h1C, {30'h0, rows[i][4:3]});
      push(rows[i][2:1]);
      rd(8'h28);
      chk(v, {31'h0, rows[i][0]});
      wr(8'h24, 32'h2);
      rd(8'h14);
      chk(v, rows[i][0] ? {16'hA53C, 16'h1234 + rows[i][2:1]} : 32'h0);
      if (rows[i][0]) lastRes = rows[i][2:1];
      @(posedge core_clk);
      rd(8'h18);
      chk(v, {30'h0, lastRes});
    end
    // masked reception, write of zero keeps it, unmask, then clear
    @(posedge core_clk);
    rxDoorbellPulse <= 1'b1;
    @(posedge core_clk);
    rxDoorbellPulse <= 1'b0;
    #1 chk(doorbellIrq, 1'b0);
    wr(8'h24, 32'h6);
    rd(8'h24);
    chk(v, 32'h1);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20);
    chk(v, 32'h7);
    chk(doorbellIrq, 1'b1);
    wr(8'h24, 32'h1);
    #1 chk(doorbellIrq, 1'b0);
    // seventeen entries into a sixteen-deep fifo
    wr(8'h1C, 32'h1);
    wr(8'h20, 32'h4);
    repeat (17) push(2'h0);
    repeat (3) @(posedge core_clk);
    #1 chk(doorbellIrq, 1'b1);
    rd(8'h28);
    chk(v, 32'h10);
    wr(8'h24, 32'h4);
    rd(8'h24);
    chk(v, 32'h6);
    rd(8'h14);
    repeat (2) @(posedge core_clk);
    wr(8'h24, 32'h4);
    rd(8'h24);
    chk(v, 32'h2);
    chk(doorbellIrq, 1'b0);
    rd(8'h30);
    chk(v, 32'h0);
    // mid-run reset returns the control, enable, status and level registers to zero
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(v, 32'h0);
    end
    // back-to-back events, status reads and clears; the tasks always leave a gap
    wr(8'h1C, 32'h1);
    wr(8'h20, 32'h3);
    @(posedge core_clk);
    rxDoorbellPulse <= 1'b1;
    txDoneValid <= 1'b1;
    txDoneData <= '{8'h11, 8'h22, 16'h3344, 2'h0};
    @(posedge core_clk);
    rxDoorbellPulse <= 1'b0;
    txDoneValid <= 1'b0;
    busReq <= '{8'h24, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    busReq <= '{8'h24, 32'h1, 1'b1, 1'b0};
    #1 chk(busRdata, 32'h3);
    chk(doorbellIrq, 1'b1);
    @(posedge core_clk);
    busReq <= '{8'h24, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    busReq <= '{8'h14, 32'h0, 1'b0, 1'b1};
    #1 chk(busRdata, 32'h2);
    @(posedge core_clk);
    busReq <= '{8'h24, 32'h2, 1'b1, 1'b0};
    #1 chk(busRdata, 32'h11223344);
    @(posedge core_clk);
    busReq.wr <= 1'b0;
    #1 chk(doorbellIrq, 1'b0);
    final_report();
  end
endmodule : dbc_core_test
`default_nettype wire
